// File: rtl/burst_sram_port.sv
// Data and load-control port of a double-data-rate two-beat burst SRAM.
//
// How it works
// - Write beats captured on both input clock phases
// - Data pins driven only during active reads
// - Read beats launched on output clock edges
// - Single clock mode launches on input edges
// - Output enable released whenever no read
// - Address and direction latched with the load
// - Every load moves exactly two beats
// - Lane masks sampled with data, skip lanes
//
// Each ref_clk edge stands for one rising edge of the input clock pair:
// k_phase high marks a true-clock edge, low marks a complement edge.
module burst_sram_port
#(
    parameter int DATA_W     = burst_port_pkg::DATA_W_DEF,
    parameter int ADDR_W     = burst_port_pkg::ADDR_W_DEF,
    parameter int FIFO_DEPTH = burst_port_pkg::FIFO_DEPTH_DEF
)
(
    // Clock, reset and freeze.
    input  wire logic                                           ref_clk,
    input  wire logic                                           rstn,
    input  wire logic                                           ce,
    // Clock phase and read-launch timing.
    input  wire logic                                           k_phase,
    input  wire logic                                           out_clk_edge,
    input  wire logic                                           single_clk_mode,
    // Transaction definition.
    input  wire logic                                           bus_cycle_strobe_n,
    input  wire logic                                           rw_sel,
    input  wire logic [ADDR_W-1:0]                              addr,
    // Shared data pins, split into three signals.
    input  wire logic [DATA_W-1:0]                              dq_in,
    input  wire logic [DATA_W/burst_port_pkg::LANE_W-1:0]       lane_write_mask_n,
    output      logic [DATA_W-1:0]                              dq_out,
    output      logic                                           dq_oe,
    // Back-pressure toward the controller.
    output      logic                                           load_ready
);
    import burst_port_pkg::*;

    // One array word per address, so the array depth follows the address width.
    localparam int NL    = DATA_W / LANE_W;
    localparam int DEPTH = 1 << ADDR_W;
    localparam int EW    = ADDR_W + DATA_W + NL;

    // Lanes must tile the word exactly; refused while elaborating.
    if (DATA_W % LANE_W != 0 || ADDR_W < 1)
    begin
        $error("burst_sram_port: DATA_W must be a multiple of LANE_W, ADDR_W >= 1");
    end

    // Whole control state of the port.
    typedef struct packed
    {
        port_state_e       st;          // Sequencer state.
        logic [ADDR_W-1:0] base;        // Address latched with the load.
        logic [DATA_W-1:0] dq_out;      // Word on the pins.
        logic              dq_oe;       // Pins driven.
        logic              load_ready;  // Buffer can take one more burst.
    } port_s;

    port_s             q;                // Registered state.
    port_s             d;                // Next state.
    logic [DATA_W-1:0] mem [DEPTH];      // Storage array.
    logic              load_take;        // Load accepted this edge.
    logic              launch;           // Read launch edge.

    // Buffer channels between sequencer and storage.
    wbuf_if #(.W(EW)) wb ();

    // The write buffer absorbs beats at twice the array's write rate.
    wbuf_fifo #(.W(EW), .DEPTH(FIFO_DEPTH)) u_wbuf
    (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .ce      (ce),
        .bus     (wb.store)
    );

    // Burst counter: the low address bit is flipped on the second beat.
    function automatic logic [ADDR_W-1:0] beat_addr(input logic [ADDR_W-1:0] a,
                                                    input logic              beat);
        beat_addr = a ^ ADDR_W'(beat);
    endfunction

    // Loads are only taken on a true-clock edge with the strobe low.
    // A high strobe leaves address and direction unread.
    assign load_take = !bus_cycle_strobe_n && k_phase && q.load_ready;

    // Read beats follow the output clock pair, or the input pair in single mode.
    // Launch edges arrive as a pulse, so no second clock domain is needed here.
    assign launch = single_clk_mode ? 1'b1 : out_clk_edge;

    // Sequencer: decides every beat and the pin drive.
    always_comb
    begin
        d              = q;
        wb.in_valid    = 1'b0;
        wb.in_data     = '0;
        d.load_ready   = wb.room_burst;
        // The array writes once per input clock cycle and never from the first read beat to the release.
        wb.out_ready   = k_phase && (q.st != ST_RD_BEAT0) && (q.st != ST_RD_BEAT1)
                         && (q.st != ST_RD_END);
        case (q.st)
            ST_IDLE:
            begin
                // A missing or refused load simply leaves the sequencer idle.
                // Address and direction are latched in the same cycle.
                if (load_take)
                begin
                    d.base = addr;
                    d.st   = rw_sel ? ST_RD_WAIT : ST_WR_BEAT0;
                end
            end
            ST_WR_BEAT0:
            begin
                // First beat with its lane masks goes into the buffer.
                wb.in_valid = 1'b1;
                wb.in_data  = {beat_addr(q.base, 1'b0), dq_in, lane_write_mask_n};
                d.st        = ST_WR_BEAT1;
            end
            ST_WR_BEAT1:
            begin
                // Second beat closes the burst; a new load may overlap it.
                wb.in_valid = 1'b1;
                wb.in_data  = {beat_addr(q.base, 1'b1), dq_in, lane_write_mask_n};
                d.st        = ST_IDLE;
                if (load_take)
                begin
                    d.base = addr;
                    d.st   = rw_sel ? ST_RD_WAIT : ST_WR_BEAT0;
                end
            end
            ST_RD_WAIT:
            begin
                // Pending writes drain first so a read never sees stale data.
                // Variable read latency is the price of this read-after-write safety.
                if (!wb.out_valid)
                    d.st = ST_RD_BEAT0;
            end
            ST_RD_BEAT0:
            begin
                // Hold here until the next launch edge of the read clock.
                if (launch)
                begin
                    d.dq_out = mem[beat_addr(q.base, 1'b0)];
                    d.dq_oe  = 1'b1;
                    d.st     = ST_RD_BEAT1;
                end
            end
            ST_RD_BEAT1:
            begin
                // The second word comes from the partner address of the burst.
                if (launch)
                begin
                    d.dq_out = mem[beat_addr(q.base, 1'b1)];
                    d.st     = ST_RD_END;
                end
            end
            ST_RD_END:
            begin
                // Release the pins on the edge after the second beat.
                if (launch)
                begin
                    d.dq_oe = 1'b0;
                    d.st    = ST_IDLE;
                end
            end
            default:
            begin
                // An illegal state falls back to idle with the pins released.
                d.st    = ST_IDLE;
                d.dq_oe = 1'b0;
            end
        endcase
        // Nothing else may enable the pins outside a read.
        if (d.st == ST_IDLE || d.st == ST_WR_BEAT0 || d.st == ST_WR_BEAT1)
            d.dq_oe = 1'b0;
    end

    // State register; a low clock enable freezes everything.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q            <= '0;
            q.st         <= ST_IDLE;
            q.dq_oe      <= RST_OE;
            q.load_ready <= RST_LOAD_READY;
        end
        else if (ce)
            q <= d;
    end

    // Array write: a lane with its mask high keeps its old contents.
    always_ff @(posedge ref_clk)
    begin
        if (ce && wb.out_valid && wb.out_ready)
        begin
            // Lane i is written only when its mask bit is low.
            for (int i = 0; i < NL; i++)
            begin
                if (!wb.out_data[i])
                    mem[wb.out_data[EW-1 -: ADDR_W]][i*LANE_W +: LANE_W] <=
                        wb.out_data[NL + i*LANE_W +: LANE_W];
            end
        end
    end

    // Outputs come straight from the state register.
    // The pad that owns the tristate sits outside; dq_oe high means drive.
    assign dq_out     = q.dq_out;
    assign dq_oe      = q.dq_oe;
    assign load_ready = q.load_ready;

endmodule

// File: rtl/burst_port_pkg.sv
// Shared constants for the burst SRAM data and load port.
package burst_port_pkg;

    // Word width of one data beat and of one masked lane.
    localparam int DATA_W_DEF  = 36;
    localparam int LANE_W      = 9;

    // External word address width; the low bit feeds the burst counter.
    localparam int ADDR_W_DEF  = 21;

    // Beats moved by every accepted load.
    localparam int BURST_LEN   = 2;

    // Depth of the write buffer in front of the storage array.
    localparam int FIFO_DEPTH_DEF = 8;

    // Free entries the buffer must offer before a new load is taken.
    localparam int LOAD_MARGIN = 2 * BURST_LEN;

    // Reset values of the outward flags.
    localparam logic RST_OE         = 1'b0;
    localparam logic RST_LOAD_READY = 1'b1;

    // Sequencer states of the port.
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_WR_BEAT0,
        ST_WR_BEAT1,
        ST_RD_WAIT,
        ST_RD_BEAT0,
        ST_RD_BEAT1,
        ST_RD_END
    } port_state_e;

endpackage

// File: rtl/wbuf_if.sv
// Valid/ready channel pair between the port sequencer and its write buffer.
interface wbuf_if #(parameter int W = 8);

    logic [W-1:0] in_data;     // Entry offered by the sequencer.
    logic         in_valid;    // Sequencer holds an entry.
    logic         in_ready;    // Buffer has a free slot.
    logic         room_burst;  // Buffer can take a whole burst and a spare one.
    logic [W-1:0] out_data;    // Oldest entry.
    logic         out_valid;   // Buffer is not empty.
    logic         out_ready;   // Storage array takes the oldest entry.

    // Side that fills the buffer.
    modport fill  (output in_data, output in_valid, input in_ready, input room_burst,
                   input out_data, input out_valid, output out_ready);

    // The buffer itself.
    modport store (input in_data, input in_valid, output in_ready, output room_burst,
                   output out_data, output out_valid, input out_ready);

endinterface

// File: rtl/wbuf_fifo.sv
// Parameterised write buffer with valid and ready on both sides.
module wbuf_fifo
#(
    parameter int W     = 8,
    parameter int DEPTH = burst_port_pkg::FIFO_DEPTH_DEF
)
(
    // Clock, reset and freeze.
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic ce,
    // Buffer channels.
    wbuf_if.store     bus
);
    import burst_port_pkg::*;

    localparam int PW = $clog2(DEPTH);

    // Pointer width only works for a power-of-two depth; refused while elaborating.
    if (DEPTH < LOAD_MARGIN || (1 << PW) != DEPTH)
    begin
        $error("wbuf_fifo: DEPTH must be a power of two not below the load margin");
    end

    // Whole control state of the buffer.
    typedef struct packed
    {
        logic [PW-1:0] wp;     // Next slot to fill.
        logic [PW-1:0] rp;     // Oldest filled slot.
        logic [PW:0]   count;  // Filled slots.
    } fifo_s;

    fifo_s        q;                 // Registered state.
    fifo_s        d;                 // Next state.
    logic [W-1:0] mem [DEPTH];       // Entry storage.
    logic         push;              // Entry accepted this cycle.
    logic         pop;               // Entry drained this cycle.

    // Full and empty come straight from the count so they never lie.
    assign bus.in_ready   = (q.count != (PW + 1)'(DEPTH));
    assign bus.out_valid  = (q.count != '0);
    assign bus.out_data   = mem[q.rp];
    assign bus.room_burst = (q.count <= (PW + 1)'(DEPTH - LOAD_MARGIN));
    assign push           = bus.in_valid && bus.in_ready;
    assign pop            = bus.out_valid && bus.out_ready;

    // Pointer and count update.
    always_comb
    begin
        d = q;
        if (push)
            d.wp = q.wp + 1'b1;
        if (pop)
            d.rp = q.rp + 1'b1;
        // Simultaneous push and pop leave the count unchanged.
        d.count = q.count + (PW + 1)'(push) - (PW + 1)'(pop);
    end

    // State register; a low clock enable freezes everything.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            q <= '0;
        else if (ce)
            q <= d;
    end

    // Storage has no reset; only the slot being filled is written.
    always_ff @(posedge ref_clk)
    begin
        if (ce && push)
            mem[q.wp] <= bus.in_data;
    end

endmodule

// File: test/port_monitor.sv
// Checker for the outward timing of the burst SRAM port.
module port_monitor
#(
    parameter int DATA_W = 36
)
(
    // Clock, reset and timing inputs.
    input wire logic              ref_clk,
    input wire logic              rstn,
    input wire logic              ce,
    input wire logic              k_phase,
    input wire logic              out_clk_edge,
    input wire logic              single_clk_mode,
    // Commands.
    input wire logic              bus_cycle_strobe_n,
    input wire logic              rw_sel,
    // Outputs under watch.
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic              dq_oe,
    input wire logic              load_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    import burst_port_pkg::*;

    logic       launch;    // This edge may launch a read word.
    logic [5:0] rd_gap_q;  // Cycles since a read request; saturates so it never wraps.
    assign launch = ce && (single_clk_mode || out_clk_edge);

    // Reads may wait for the write buffer to drain, so the bound is generous.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            rd_gap_q <= 6'h3f;
        else if (ce && k_phase && !bus_cycle_strobe_n && rw_sel)
            rd_gap_q <= 6'h00;
        else if (ce && rd_gap_q != 6'h3f)
            rd_gap_q <= rd_gap_q + 6'h01;
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    property p_rst_out; $rose(rstn) |-> !dq_oe && dq_out == '0 && load_ready; endproperty
    property p_oe_rise; $rose(dq_oe) |-> $past(launch); endproperty
    property p_oe_fall; $fell(dq_oe) |-> $past(launch); endproperty
    property p_out_hold; !$past(launch) |-> $stable(dq_out); endproperty
    property p_oe_len; $rose(dq_oe) && single_clk_mode |=> dq_oe ##1 !dq_oe; endproperty
    property p_oe_gap; $fell(dq_oe) |=> !dq_oe [*2]; endproperty
    property p_oe_cause; dq_oe |-> rd_gap_q < 6'h32; endproperty
    property p_wr_quiet;
        ce && k_phase && !bus_cycle_strobe_n && !rw_sel && !dq_oe |=> !dq_oe [*2];
    endproperty

    a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
    a_oe_rise: assert property (p_oe_rise) else $error("drive began off a launch edge");
    a_oe_fall: assert property (p_oe_fall) else $error("drive ended off a launch edge");
    a_out_hold: assert property (p_out_hold) else $error("read word moved between edges");
    a_oe_len: assert property (p_oe_len) else $error("read did not span two beats");
    a_oe_gap: assert property (p_oe_gap) else $error("drive resumed too soon");
    a_oe_cause: assert property (p_oe_cause) else $error("drive without a read request");
    a_wr_quiet: assert property (p_wr_quiet) else $error("write request drove the pins");

    c_rd_single: cover property ($rose(dq_oe) && single_clk_mode);
    c_rd_dual: cover property ($rose(dq_oe) && !single_clk_mode);
    c_full: cover property ($fell(load_ready));
endmodule

bind burst_sram_port port_monitor #(.DATA_W(DATA_W)) port_monitor_inst (.ref_clk(ref_clk),
    .rstn(rstn), .ce(ce), .k_phase(k_phase), .out_clk_edge(out_clk_edge),
    .single_clk_mode(single_clk_mode), .bus_cycle_strobe_n(bus_cycle_strobe_n),
    .rw_sel(rw_sel), .dq_out(dq_out), .dq_oe(dq_oe), .load_ready(load_ready));

// File: test/ctrl_model.sv
// Memory controller model that drives commands and write beats into the port.
module ctrl_model
    import burst_port_pkg::*;
(
    // Clock and status from the port.
    input  wire logic                ref_clk,
    input  wire logic                load_ready,
    input  wire logic                dq_oe,
    input  wire logic [DATA_W_DEF-1:0] dq_out,
    // Commands and data toward the port.
    output logic                     k_phase,
    output logic                     out_clk_edge,
    output logic                     strobe_n,
    output logic                     rw,
    output logic [3:0]               addr,
    output logic [DATA_W_DEF-1:0]    dq_in,
    output logic [3:0]               mask_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic slow;  // Output clock at half rate, so dual-clock reads launch every other edge.
    logic one_clk;  // Port launches on every input edge, whatever the output clock does.
    logic drv;   // The controller owns the data pins.
    initial
    begin
        {k_phase, out_clk_edge, rw, slow, drv} = 5'h00;
        one_clk = 1'b1;
        {strobe_n, addr, dq_in, mask_n} = '1;
    end

    // Clock phases alternate; released pins never keep their last value.
    always @(negedge ref_clk)
    begin
        k_phase      <= !k_phase;
        out_clk_edge <= slow ? !out_clk_edge : 1'b1;
        if (!drv)
        begin
            dq_in  <= ~dq_in;
            mask_n <= ~mask_n;
        end
    end

    // Word stored for an even address and beat.
    function automatic logic [35:0] dv(input logic [3:0] a, input logic b);
        return {a, b, 31'h2d3c_4b5a};
    endfunction

    // Stops at the falling edge before a true-clock edge that can take a load.
    task automatic sync_load(output logic ok);
        int n;
        n = 0;
        ok = 0;
        while (!ok && n < 400)
        begin
            @(negedge ref_clk);
            ok = k_phase === 1'b0 && load_ready === 1'b1;
            n++;
        end
    endtask

    // Back-to-back write loads, each overlapping the last beat of the one before.
    task automatic wr_seq(input logic [3:0] a0, input int n, input logic [3:0] m0,
                          input logic [3:0] m1, input logic inv, output int done);
        logic       ok;
        logic [3:0] a;
        done = 0;
        a = a0;
        sync_load(ok);
        drv = 1;
        while (ok)
        begin
            strobe_n <= 1'b0;
            rw <= 1'b0;
            addr <= a;
            if (done > 0)
            begin
                dq_in <= dv(a - 4'h2, 1'b1) ^ {36{inv}};
                mask_n <= m1;
            end
            @(negedge ref_clk);
            strobe_n <= 1'b1;
            rw <= 1'b1;
            addr <= ~a;
            dq_in <= dv(a, 1'b0) ^ {36{inv}};
            mask_n <= m0;
            done++;
            a = a + 4'h2;
            @(negedge ref_clk);
            ok = done < n && load_ready === 1'b1;
        end
        dq_in <= dv(a - 4'h2, 1'b1) ^ {36{inv}};
        mask_n <= m1;
        @(negedge ref_clk);
        drv = 0;
    endtask

    // One read load; returns both words and the drive flag after each beat.
    task automatic rd(input logic [3:0] a, output logic [35:0] q0, output logic [35:0] q1,
                      output logic [1:0] oe);
        logic ok;
        int   n;
        sync_load(ok);
        strobe_n <= 1'b0;
        rw <= 1'b1;
        addr <= a;
        @(negedge ref_clk);
        strobe_n <= 1'b1;
        rw <= 1'b0;
        n = 0;
        while (dq_oe !== 1'b1 && n < 100)
        begin
            @(negedge ref_clk);
            n++;
        end
        q0 = dq_out;
        repeat ((slow && !one_clk) ? 2 : 1) @(negedge ref_clk);
        q1 = dq_out;
        oe[0] = dq_oe;
        repeat ((slow && !one_clk) ? 2 : 1) @(negedge ref_clk);
        oe[1] = dq_oe;
    endtask
endmodule

// File: test/tb_top.sv
// Self-checking bench for the burst SRAM port.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import burst_port_pkg::*;

    logic        ref_clk, rstn, ce, single_clk_mode, k_phase, out_clk_edge;
    logic        strobe_n, rw, dq_oe, load_ready;
    logic [3:0]  addr, mask_n;
    logic [35:0] dq_in, dq_out;
    logic [35:0] mem [16];  // Expected array contents.
    int          failures, check_count, cyc;

    burst_sram_port #(.ADDR_W(4)) burst_sram_port_inst (.ref_clk(ref_clk), .rstn(rstn),
        .ce(ce), .k_phase(k_phase), .out_clk_edge(out_clk_edge),
        .single_clk_mode(single_clk_mode), .bus_cycle_strobe_n(strobe_n), .rw_sel(rw),
        .addr(addr), .dq_in(dq_in), .lane_write_mask_n(mask_n), .dq_out(dq_out),
        .dq_oe(dq_oe), .load_ready(load_ready));
    ctrl_model ctrl_model_inst (.ref_clk(ref_clk), .load_ready(load_ready), .dq_oe(dq_oe),
        .dq_out(dq_out), .k_phase(k_phase), .out_clk_edge(out_clk_edge), .strobe_n(strobe_n),
        .rw(rw), .addr(addr), .dq_in(dq_in), .mask_n(mask_n));

    task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Reads a burst and compares both words and the drive window.
    task automatic t_rd(input logic [3:0] a);
        logic [35:0] q0, q1;
        logic [1:0]  oe;
        ctrl_model_inst.rd(a, q0, q1, oe);
        chk("first word", mem[a], q0);
        chk("second word", mem[a ^ 4'h1], q1);
        chk("drive window", 36'h0_0000_0001, {34'h0, oe});
    endtask

    // Outputs idle while reset is held.
    task automatic t_reset;
        chk("reset data", 36'h0_0000_0000, dq_out);
        chk("reset flags", 36'h0_0000_0001, {34'h0, dq_oe, load_ready});
    endtask

    // Writes until the buffer refuses, then reads every burst back.
    task automatic t_fill;
        int done;
        ctrl_model_inst.wr_seq(4'h0, 8, 4'h0, 4'h0, 1'b0, done);
        chk("buffer refused a load", 36'h1, {35'h0, done < 8});
        for (int i = 0; i < done; i++)
        begin
            mem[2 * i] = ctrl_model_inst.dv(4'(2 * i), 1'b0);
            mem[2 * i + 1] = ctrl_model_inst.dv(4'(2 * i), 1'b1);
            t_rd(4'(2 * i));
        end
    endtask

    // Masked write merges lanes; an odd start address reverses the burst.
    task automatic t_mask;
        int          done;
        logic [35:0] w0, w1;
        ctrl_model_inst.wr_seq(4'h2, 1, 4'h5, 4'ha, 1'b1, done);
        chk("masked load taken", 36'h0_0000_0001, 36'(done));
        w0 = ~ctrl_model_inst.dv(4'h2, 1'b0);
        w1 = ~ctrl_model_inst.dv(4'h2, 1'b1);
        for (int j = 0; j < 4; j++)
        begin
            if (j % 2 == 1)
                mem[2][9 * j +: 9] = w0[9 * j +: 9];
            else
                mem[3][9 * j +: 9] = w1[9 * j +: 9];
        end
        t_rd(4'h3);
    endtask

    // Output clock launches at half rate; an idle bus stays released.
    task automatic t_dual;
        int bad;
        bad = 0;
        ctrl_model_inst.slow = 1;
        t_rd(4'h2);
        single_clk_mode = 0;
        ctrl_model_inst.one_clk = 0;
        t_rd(4'h0);
        repeat (40) @(negedge ref_clk) bad += (dq_oe !== 1'b0);
        chk("idle drive", 36'h0, 36'(bad));
    endtask

    task automatic close_out;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        ref_clk = 0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Cuts a hang short; the whole run needs about 130 cycles.
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            close_out();
        end
    end

    initial
    begin
        {rstn, failures, check_count, cyc} = '0;
        {ce, single_clk_mode} = 2'h3;
        repeat (3) @(negedge ref_clk);
        t_reset();
        rstn = 1;
        t_fill();
        t_mask();
        t_dual();
        close_out();
    end
endmodule
